// *** hw/ida_unit.sv ***
// Indirect addressing unit: pointer registers, port redirection and unused-location zero read
`timescale 1ns/1ps
`default_nettype none
// Function
// - Unused special locations read back zero
// - Port access goes to pointer-addressed location
// - Sector-zero port reaches sector 0 only
// - Port A uses pointer A low byte plus the lowest bits of its sector byte
// - Port B uses pointer B low byte plus the lowest bits of its sector byte
// - Port location itself reads as zero
// - Write to port location itself changes nothing
// - High byte selects sector, low byte offset
module ida_unit
	import ida_pkg::*;
#(
	parameter int SECTORS = 2
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Core access request
	input wire logic [ida_pkg::ADDR_W-1:0] core_addr_i,
	input wire logic core_rd_i,
	input wire logic core_wr_i,
	input wire logic [ida_pkg::DATA_W-1:0] core_wdata_i,
	// Location is implemented somewhere in the special area
	input wire logic sfr_used_i,
	// Redirected access to data memory
	output logic [ida_pkg::ADDR_W-1:0] mem_addr_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [ida_pkg::DATA_W-1:0] mem_wdata_o,
	input wire logic [ida_pkg::DATA_W-1:0] mem_rdata_i,
	// Read data back to the core, valid the cycle after a read
	output logic [ida_pkg::DATA_W-1:0] core_rdata_o,
	// Pointer values
	output logic [ida_pkg::DATA_W-1:0] sector0_pointer_o,
	output logic [ida_pkg::DATA_W-1:0] pointer_a_low_o,
	output logic [ida_pkg::DATA_W-1:0] pointer_a_sector_o,
	output logic [ida_pkg::DATA_W-1:0] pointer_b_low_o,
	output logic [ida_pkg::DATA_W-1:0] pointer_b_sector_o
);
	import ida_pkg::*;

	// Pointer registers, in the order of the hit and next-value vectors
	localparam int PTR_N = 5;
	localparam int PTR_S0 = 0;
	localparam int PTR_A_LOW = 1;
	localparam int PTR_A_SECT = 2;
	localparam int PTR_B_LOW = 3;
	localparam int PTR_B_SECT = 4;
	localparam logic [PTR_N-1:0][7:0] PTR_ADDRS = {
		PTR_B_SECTOR_ADDR,
		PTR_B_LOW_ADDR,
		PTR_A_SECTOR_ADDR,
		PTR_A_LOW_ADDR,
		SECTOR0_PTR_ADDR
	};

	// Refuse configurations the address split cannot serve
	if (SECTORS < 1 || SECTORS > (1 << SECT_W)) begin : g_bad_sectors
		$error("SECTORS out of range");
	end
	if (ADDR_W != SECT_W + 8) begin : g_bad_addr_w
		$error("ADDR_W must be SECT_W plus one byte");
	end
	if (DATA_W != 8) begin : g_bad_data_w
		$error("Pointers must be one byte wide");
	end

	typedef struct packed {
		logic [DATA_W-1:0] sector0_pointer;
		logic [DATA_W-1:0] pointer_a_low;
		logic [DATA_W-1:0] pointer_a_sector;
		logic [DATA_W-1:0] pointer_b_low;
		logic [DATA_W-1:0] pointer_b_sector;
		logic [DATA_W-1:0] rdata;
		logic rd_mem;
		logic rd_zero;
	} ida_state_t;

	ida_state_t state_q;
	ida_state_t state_d;
	ida_port_t port_sel;
	ida_port_t target_port;
	logic in_sector0;
	logic is_sfr;
	logic sfr_void;
	logic target_void;
	logic target_low;
	logic wr_go;
	logic [SECT_W-1:0] sect_a;
	logic [SECT_W-1:0] sect_b;
	logic [ADDR_W-1:0] target_addr;
	logic [PTR_N-1:0] ptr_hit;
	logic [PTR_N-1:0][DATA_W-1:0] ptr_cur;
	logic [PTR_N-1:0][DATA_W-1:0] ptr_next;

	ida_port_decode u_dec (
		.addr_i(core_addr_i),
		.port_o(port_sel)
	);

	// Pointer that feeds an indirect port may itself name a port location
	ida_port_decode u_dec_tgt (
		.addr_i(target_addr),
		.port_o(target_port)
	);

	// Special area is the low part of sector 0
	assign in_sector0 = (core_addr_i[ADDR_W-1:8] == '0);
	assign is_sfr = in_sector0 && (core_addr_i[7:0] < SFR_LIMIT);
	assign sfr_void = (port_sel == IDA_PORT_NONE) && is_sfr && !sfr_used_i;

	// Only the lowest sector bits of a sector byte take part in the address
	assign sect_a = state_q.pointer_a_sector[SECT_W-1:0];
	assign sect_b = state_q.pointer_b_sector[SECT_W-1:0];

	always_comb begin
		case (port_sel)
			IDA_PORT_S0: begin
				target_addr = {{(ADDR_W-8){1'b0}}, state_q.sector0_pointer};
			end
			IDA_PORT_A: begin
				target_addr = {sect_a, state_q.pointer_a_low};
			end
			IDA_PORT_B: begin
				target_addr = {sect_b, state_q.pointer_b_low};
			end
			default: begin
				target_addr = core_addr_i;
			end
		endcase
	end

	// A pointer that names a port location leads nowhere: no storage behind it
	assign target_void = (port_sel != IDA_PORT_NONE) && (target_port != IDA_PORT_NONE);
	assign target_low = (target_addr[ADDR_W-1:8] == '0);
	assign wr_go = core_wr_i && !target_void;

	assign ptr_cur[PTR_S0] = state_q.sector0_pointer;
	assign ptr_cur[PTR_A_LOW] = state_q.pointer_a_low;
	assign ptr_cur[PTR_A_SECT] = state_q.pointer_a_sector;
	assign ptr_cur[PTR_B_LOW] = state_q.pointer_b_low;
	assign ptr_cur[PTR_B_SECT] = state_q.pointer_b_sector;

	// Pointers live in data memory, so a redirected write reaches them too
	for (genvar gi = 0; gi < PTR_N; gi++) begin : g_ptr
		assign ptr_hit[gi] = wr_go && target_low && (target_addr[7:0] == PTR_ADDRS[gi]);
		assign ptr_next[gi] = ptr_hit[gi] ? core_wdata_i : ptr_cur[gi];
	end

	always_comb begin
		state_d = state_q;
		state_d.rd_mem = 1'b0;
		state_d.rd_zero = 1'b0;
		mem_addr_o = target_addr;
		mem_rd_o = 1'b0;
		mem_wr_o = 1'b0;
		mem_wdata_o = core_wdata_i;
		// Reads: redirected or direct, unless nothing stands behind the location
		if (core_rd_i) begin
			if (target_void) begin
				state_d.rd_zero = 1'b1;
			end else if (sfr_void) begin
				state_d.rd_zero = 1'b1;
			end else begin
				mem_rd_o = 1'b1;
				state_d.rd_mem = 1'b1;
			end
		end
		// Writes: a void target takes nothing; an unused location gets no memory write, but a pointer at that address still loads
		if (core_wr_i) begin
			if (target_void) begin
				mem_wr_o = 1'b0;
			end else if (sfr_void) begin
				mem_wr_o = 1'b0;
			end else begin
				mem_wr_o = 1'b1;
			end
		end
		state_d.sector0_pointer = ptr_next[PTR_S0];
		state_d.pointer_a_low = ptr_next[PTR_A_LOW];
		state_d.pointer_a_sector = ptr_next[PTR_A_SECT];
		state_d.pointer_b_low = ptr_next[PTR_B_LOW];
		state_d.pointer_b_sector = ptr_next[PTR_B_SECT];
		// Hold the last read byte once the memory moves on
		if (state_q.rd_zero) begin
			state_d.rdata = ZERO_BYTE;
		end else if (state_q.rd_mem) begin
			state_d.rdata = mem_rdata_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_q.sector0_pointer <= PTR_RESET;
			state_q.pointer_a_low <= PTR_RESET;
			state_q.pointer_a_sector <= PTR_RESET;
			state_q.pointer_b_low <= PTR_RESET;
			state_q.pointer_b_sector <= PTR_RESET;
			state_q.rdata <= ZERO_BYTE;
			state_q.rd_mem <= 1'b0;
			state_q.rd_zero <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	// Read byte: the memory's answer in the cycle after the read, then the held copy
	always_comb begin
		if (state_q.rd_zero) begin
			core_rdata_o = ZERO_BYTE;
		end else if (state_q.rd_mem) begin
			core_rdata_o = mem_rdata_i;
		end else begin
			core_rdata_o = state_q.rdata;
		end
	end

	assign sector0_pointer_o = state_q.sector0_pointer;
	assign pointer_a_low_o = state_q.pointer_a_low;
	assign pointer_a_sector_o = state_q.pointer_a_sector;
	assign pointer_b_low_o = state_q.pointer_b_low;
	assign pointer_b_sector_o = state_q.pointer_b_sector;
endmodule
`default_nettype wire

// *** hw/ida_pkg.sv ***
// Package: addresses, widths and pointer locations of the indirect addressing unit
package ida_pkg;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int SECT_W = 1;
	localparam logic [7:0] PORT_SECTOR0_ADDR = 8'h00;
	localparam logic [7:0] SECTOR0_PTR_ADDR = 8'h01;
	localparam logic [7:0] PORT_A_ADDR = 8'h02;
	localparam logic [7:0] PTR_A_LOW_ADDR = 8'h03;
	localparam logic [7:0] PTR_A_SECTOR_ADDR = 8'h04;
	localparam logic [7:0] PORT_B_ADDR = 8'h0C;
	localparam logic [7:0] PTR_B_LOW_ADDR = 8'h0D;
	localparam logic [7:0] PTR_B_SECTOR_ADDR = 8'h0E;
	localparam logic [7:0] SFR_LIMIT = 8'h80;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	typedef enum logic [1:0] {
		IDA_PORT_NONE = 2'b00,
		IDA_PORT_S0 = 2'b01,
		IDA_PORT_A = 2'b10,
		IDA_PORT_B = 2'b11
	} ida_port_t;
endpackage

// *** hw/ida_port_decode.sv ***
// Decoder: which indirect access port a core address names
`timescale 1ns/1ps
`default_nettype none
module ida_port_decode
	import ida_pkg::*;
(
	// Address in
	input wire logic [ida_pkg::ADDR_W-1:0] addr_i,
	// Port selected
	output ida_pkg::ida_port_t port_o
);
	import ida_pkg::*;
	always_comb begin
		port_o = IDA_PORT_NONE;
		if (addr_i[ADDR_W-1:8] == '0) begin
			case (addr_i[7:0])
				PORT_SECTOR0_ADDR: port_o = IDA_PORT_S0;
				PORT_A_ADDR: port_o = IDA_PORT_A;
				PORT_B_ADDR: port_o = IDA_PORT_B;
				default: port_o = IDA_PORT_NONE;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** verif/ida_unit_monitor.sv ***
// Checker: redirection and zero reads of the indirect addressing unit
`timescale 1ns/1ps
`default_nettype none
module ida_unit_monitor (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Core request
	input wire logic core_rd_i,
	input wire logic core_wr_i,
	input wire logic [8:0] core_addr_i,
	input wire logic sfr_used_i,
	// Memory side and read data
	input wire logic mem_rd_o,
	input wire logic mem_wr_o,
	input wire logic [8:0] mem_addr_o,
	input wire logic [7:0] core_rdata_o,
	// Pointers
	input wire logic [7:0] sector0_pointer_o,
	input wire logic [7:0] pointer_a_low_o,
	input wire logic [7:0] pointer_a_sector_o,
	input wire logic [7:0] pointer_b_low_o,
	input wire logic [7:0] pointer_b_sector_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	wire logic ps = core_addr_i == 9'h000;
	wire logic pa = core_addr_i == 9'h002;
	wire logic pb = core_addr_i == 9'h00C;
	// Pointer target lies beyond the port locations
	wire logic ta = pointer_a_sector_o[0] || pointer_a_low_o[7:4] != 4'h0;
	wire logic tb = pointer_b_sector_o[0] || pointer_b_low_o[7:4] != 4'h0;
	property p_un; core_rd_i && core_addr_i[8:4] == 5'h07 && !sfr_used_i |=> core_rdata_o == 8'h00; endproperty
	a_un: assert property (p_un) else $error("unused read");
	property p_s0; core_rd_i && ps && sector0_pointer_o[7:4] != 4'h0 |-> mem_rd_o && mem_addr_o == {1'b0, sector0_pointer_o}; endproperty
	a_s0: assert property (p_s0) else $error("sector0 port");
	property p_s0s; (mem_rd_o || mem_wr_o) && ps |-> !mem_addr_o[8]; endproperty
	a_s0s: assert property (p_s0s) else $error("sector0 reach");
	property p_a; core_rd_i && pa && ta |-> mem_rd_o && mem_addr_o == {pointer_a_sector_o[0], pointer_a_low_o}; endproperty
	a_a: assert property (p_a) else $error("port a");
	property p_b; core_wr_i && pb && tb |-> mem_wr_o && mem_addr_o == {pointer_b_sector_o[0], pointer_b_low_o}; endproperty
	a_b: assert property (p_b) else $error("port b");
	property p_zr; core_rd_i && pa && !ta && pointer_a_low_o == 8'h0C |=> core_rdata_o == 8'h00; endproperty
	a_zr: assert property (p_zr) else $error("port read");
	property p_nw; core_wr_i && pb && !tb && pointer_b_low_o == 8'h02 |-> !mem_wr_o; endproperty
	a_nw: assert property (p_nw) else $error("port write");
	property p_sel; core_rd_i && pa && ta |-> mem_addr_o[8] == pointer_a_sector_o[0]; endproperty
	a_sel: assert property (p_sel) else $error("sector select");
	c_a: cover property (core_rd_i && pa && ta);
	c_b: cover property (core_wr_i && pb && tb);
	c_un: cover property (core_rd_i && !sfr_used_i);
	c_zr: cover property (core_rd_i && pa && !ta);
endmodule
bind ida_unit ida_unit_monitor mon (
	.clock_i(clock_i),
	.rst_n_i(rst_n_i),
	.core_rd_i(core_rd_i),
	.core_wr_i(core_wr_i),
	.core_addr_i(core_addr_i),
	.sfr_used_i(sfr_used_i),
	.mem_rd_o(mem_rd_o),
	.mem_wr_o(mem_wr_o),
	.mem_addr_o(mem_addr_o),
	.core_rdata_o(core_rdata_o),
	.sector0_pointer_o(sector0_pointer_o),
	.pointer_a_low_o(pointer_a_low_o),
	.pointer_a_sector_o(pointer_a_sector_o),
	.pointer_b_low_o(pointer_b_low_o),
	.pointer_b_sector_o(pointer_b_sector_o)
);
`default_nettype wire

// *** verif/ida_unit_tb_top.sv ***
// Testbench: pointer setup, redirection and zero reads of the indirect addressing unit
`timescale 1ns/1ps
`default_nettype none
module ida_unit_tb_top;
	logic clock_i = 0, rst_n_i = 0, core_rd_i = 0, core_wr_i = 0, sfr_used_i = 1, mem_rd_o, mem_wr_o;
	logic [8:0] core_addr_i = 0, mem_addr_o;
	logic [7:0] core_wdata_i = 0, mem_rdata_i = 0, mem_wdata_o, core_rdata_o, sector0_pointer_o;
	logic [7:0] pointer_a_low_o, pointer_a_sector_o, pointer_b_low_o, pointer_b_sector_o, mem [512];
	int fail_count = 0, checked = 0;
	ida_unit #(.SECTORS(2)) uut (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.core_addr_i(core_addr_i),
		.core_rd_i(core_rd_i),
		.core_wr_i(core_wr_i),
		.core_wdata_i(core_wdata_i),
		.sfr_used_i(sfr_used_i),
		.mem_addr_o(mem_addr_o),
		.mem_rd_o(mem_rd_o),
		.mem_wr_o(mem_wr_o),
		.mem_wdata_o(mem_wdata_o),
		.mem_rdata_i(mem_rdata_i),
		.core_rdata_o(core_rdata_o),
		.sector0_pointer_o(sector0_pointer_o),
		.pointer_a_low_o(pointer_a_low_o),
		.pointer_a_sector_o(pointer_a_sector_o),
		.pointer_b_low_o(pointer_b_low_o),
		.pointer_b_sector_o(pointer_b_sector_o)
	);
	always #50 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		if (mem_wr_o) mem[mem_addr_o] <= mem_wdata_o;
		if (mem_rd_o) mem_rdata_i <= mem[mem_addr_o];
	end
	task automatic chk(input string n, input logic [7:0] s, e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d = 0, input logic u = 1);
		@(posedge clock_i);
		{core_wr_i, core_rd_i, core_addr_i, core_wdata_i, sfr_used_i} <= {w, !w, a, d, u};
		@(posedge clock_i);
		{core_wr_i, core_rd_i} <= 2'b00;
		@(negedge clock_i);
	endtask
	task automatic t_s0;
		acc(1, 9'h001, 8'h40);
		acc(1, 9'h000, 8'h77);
		chk("s0", mem[9'h040], 8'h77);
		chk("s1", mem[9'h140], 8'hA0);
		acc(0, 9'h000);
		chk("s0r", core_rdata_o, 8'h77);
	endtask
	task automatic t_ab;
		acc(1, 9'h003, 8'h20);
		acc(1, 9'h004, 8'h01);
		acc(0, 9'h002);
		chk("a1", core_rdata_o, 8'h90);
		acc(1, 9'h004, 8'h00);
		acc(0, 9'h002);
		chk("a0", core_rdata_o, 8'h10);
		acc(1, 9'h00D, 8'h33);
		acc(1, 9'h00E, 8'h03);
		acc(1, 9'h00C, 8'h9C);
		chk("b", mem[9'h133], 8'h9C);
	endtask
	task automatic t_zero;
		acc(1, 9'h003, 8'h0C);
		acc(0, 9'h002);
		chk("pr", core_rdata_o, 8'h00);
		acc(1, 9'h00D, 8'h02);
		acc(1, 9'h00E, 8'h00);
		acc(1, 9'h00C, 8'h55);
		chk("pw", mem[9'h002], 8'h01);
		acc(0, 9'h079, 0, 0);
		chk("un", core_rdata_o, 8'h00);
	endtask
	task automatic t_rst;
		acc(1, 9'h001, 8'h5A);
		acc(1, 9'h003, 8'h6B);
		acc(1, 9'h004, 8'h01);
		acc(1, 9'h00D, 8'h7C);
		acc(1, 9'h00E, 8'h01);
		chk("p0", sector0_pointer_o, 8'h5A);
		chk("pal", pointer_a_low_o, 8'h6B);
		chk("pah", pointer_a_sector_o, 8'h01);
		chk("pbl", pointer_b_low_o, 8'h7C);
		chk("pbh", pointer_b_sector_o, 8'h01);
		acc(1, 9'h004, 8'h00);
		acc(1, 9'h003, 8'h0D);
		acc(1, 9'h002, 8'h21);
		chk("pind", pointer_b_low_o, 8'h21);
		acc(0, 9'h000);
		chk("s0b", core_rdata_o, 8'h2D);
		acc(1, 9'h150, 8'hEE);
		chk("hold", core_rdata_o, 8'h2D);
		@(posedge clock_i);
		rst_n_i <= 0;
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1;
		@(negedge clock_i);
		chk("r0", sector0_pointer_o, 8'h00);
		chk("ral", pointer_a_low_o, 8'h00);
		chk("rah", pointer_a_sector_o, 8'h00);
		chk("rbl", pointer_b_low_o, 8'h00);
		chk("rbh", pointer_b_sector_o, 8'h00);
		acc(1, 9'h00C, 8'h99);
		chk("rw", mem[9'h000], 8'h00);
	endtask
	task automatic results;
		if (fail_count == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 512; i++) mem[i] = 8'(i >> 1);
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1;
		t_s0;
		t_ab;
		t_zero;
		t_rst;
		results;
	end
	initial begin
		repeat (300) @(posedge clock_i);
		fail_count++;
		results;
	end
endmodule
`default_nettype wire
